// >>> rtl/sws_pkg.sv
// Purpose: Shared constants for the stop-state wakeup sequencer
// Assumes: sys_clk at 250 MHz; one T cycle is half a sys_clk cycle
// Notes: Counts are kept in T cycles and converted where used
package sws_pkg;
   localparam int unsigned T_PER_CLK = 2;
   localparam int unsigned T_PER_ICYC = 4;
   localparam int unsigned STOP_ICYC = 8;
   localparam int unsigned STOP_INSTR_T = STOP_ICYC * T_PER_ICYC;
   localparam int unsigned WAKE_SYNC_T = 3;
   localparam int unsigned LONG_DELAY_T = 131072;
   localparam int unsigned SHORT_DELAY_T = 16;
   localparam int unsigned LONG_TOTAL_T = 131104;
   localparam int unsigned SHORT_TOTAL_T = 48;
   localparam int unsigned NOP_EXTRA_T = STOP_INSTR_T + WAKE_SYNC_T;
   localparam int unsigned OSC_MARGIN_T = 19000;
   localparam int unsigned RST_EXT_SHORT_T = 50;
   localparam int unsigned RST_EXT_LONG_T = 150000;
   localparam int unsigned CNT_W = 18;
   localparam int unsigned RESUME_CYC = 8;
   localparam int unsigned RESUME_CLK = (RESUME_CYC * T_PER_ICYC) / T_PER_CLK;
   localparam int unsigned DELAY_AT_CYCLE = 4;
   localparam int unsigned SAMPLE_FROM_CYCLE = 6;
   localparam logic [15:0] WAKE_VECTOR_ADDR = 16'h0010;
   localparam logic [15:0] WAKE_VECTOR_ADDR2 = 16'h0011;
   localparam logic [CNT_W-1:0] RESUME_RST = 18'h00000;

   typedef enum logic [2:0]
   {
      SWS_RUN = 3'b000,
      SWS_STOPPED = 3'b001,
      SWS_DELAY = 3'b010,
      SWS_RESUME = 3'b011,
      SWS_DEBUG = 3'b100
   } sws_state_t;

   typedef enum logic [1:0]
   {
      SWS_EXIT_NONE = 2'b00,
      SWS_EXIT_NEXT = 2'b01,
      SWS_EXIT_VECTOR = 2'b10,
      SWS_EXIT_HIGHER = 2'b11
   } sws_exit_t;

   function automatic logic [CNT_W-1:0] sws_clk_count(input int unsigned t_cycles);
      sws_clk_count = CNT_W'((t_cycles + T_PER_CLK - 1) / T_PER_CLK);
   endfunction : sws_clk_count
endpackage : sws_pkg

// >>> rtl/sws_delay_counter.sv
// Purpose: Stabilization delay down-counter
// Assumes: Loaded once per wake; counts sys_clk cycles
// Notes: Done is registered, set on the same edge the count reaches zero
`timescale 1ns/10ps
module sws_delay_counter
   import sws_pkg::*;
#(
   parameter int unsigned W = CNT_W
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic abort,
   // Status
   output logic busy,
   output logic done
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || abort)
      begin
         cnt_r <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (load)
      begin
         cnt_r <= load_val; // (R20)
         busy <= 1'b1;
         done <= 1'b0;
      end
      else if (busy)
      begin
         // Fixed count, irregular first oscillator cycles do not matter
         cnt_r <= cnt_r - W'(1); // (R09)
         done <= (cnt_r == W'(1));
         busy <= (cnt_r != W'(1));
      end
      else
      begin
         done <= 1'b0;
      end
   end
endmodule : sws_delay_counter

// >>> rtl/sws_sequencer.sv
// Operation
// (R01) Wake serviced only if level sensitive
// (R02) Line low from delay end to cycle 8
// (R03) Higher pending level wins arbitration
// (R04) No wake, nothing pending: next instruction
// (R05) Recognized wake fetches vector pair
// (R06) Pending stack error survives stop
// (R07) Partner holds wake until feedback seen
// (R08) Sequence lasts 131104 or 48 T
// (R09) Fixed delay count regardless of oscillator
// (R10) Stop with wake low acts as NOP
// (R11) Stop is 32 T, sync 3 T
// (R12) Edge requests cleared during delay
// (R13) Reset skips delay, drops pending interrupts
// (R14) No internal timer after reset
// (R15) Brief wake pulse starts delay counter
// (R16) Debug state halts core under debug port
// (R17) Delay select picks 16 or 131072 T
// (R18) One T is half clock
// (R19) Wake, reset or timer ends stop
// (R20) Down-counter loaded on wake releases clocks
//
// Purpose: Sequences core stop entry, wake, delay and resume
// Assumes: All inputs synchronous to sys_clk; wake_level_mode from the interrupt setup
// Notes: Resume time after the delay covers the remaining stop cycles
`timescale 1ns/10ps
module sws_sequencer
   import sws_pkg::*;
#(
   parameter int unsigned LONG_DELAY = LONG_DELAY_T,
   parameter int unsigned SHORT_DELAY = SHORT_DELAY_T
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Core requests
   input wire logic stop_exec,
   input wire logic debug_req,
   input wire logic debug_release,
   input wire logic stop_delay_select,
   input wire logic wake_level_mode,
   input wire logic timer_zero,
   // Interrupt status
   input wire logic higher_pending,
   input wire logic stack_err_set,
   input wire logic stack_err_ack,
   input wire logic edge_irq_set,
   // Wake line
   input wire logic ext_wake_int_a_n,
   // Outputs to core
   output logic core_clk_en,
   output logic osc_en,
   output logic stopped,
   output logic debug_halt,
   output logic resume_pulse,
   output logic vector_fetch,
   output logic [15:0] fetch_addr,
   output logic higher_grant,
   output logic stack_err_pending,
   output logic edge_irq_pending
);
   localparam logic [CNT_W-1:0] LONG_CLK = sws_clk_count(LONG_DELAY);
   localparam logic [CNT_W-1:0] SHORT_CLK = sws_clk_count(SHORT_DELAY);
   localparam logic [CNT_W-1:0] RESUME_LOAD = CNT_W'(RESUME_CLK);

   sws_state_t state_r;
   logic [CNT_W-1:0] resume_cnt_r;
   logic wake_low_r;
   logic delay_load;
   logic delay_busy;
   logic delay_done;

   // Wake line is synchronous; the extra flop models the 3 T sync slot
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         wake_low_r <= 1'b0;
      else
         wake_low_r <= !ext_wake_int_a_n; // (R11)
   end

   // Any low pulse on the line, even short, starts the count
   assign delay_load = ((state_r == SWS_STOPPED) && (wake_low_r || timer_zero))
      || ((state_r == SWS_RUN) && stop_exec && wake_low_r && !debug_req); // (R15) (R19)

   sws_delay_counter #(
      .W(CNT_W)
   ) u_delay (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(delay_load),
      .load_val(stop_delay_select ? SHORT_CLK : LONG_CLK), // (R17) (R18)
      .abort(1'b0),
      .busy(delay_busy),
      .done(delay_done)
   );

   // Reset is synchronous and wins from any state, no delay count
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_r <= SWS_RUN; // (R13) (R14)
         resume_cnt_r <= RESUME_RST;
      end
      else
      begin
         unique case (state_r)
            SWS_RUN:
            begin
               if (debug_req)
                  state_r <= SWS_DEBUG;
               else if (stop_exec && wake_low_r)
                  state_r <= SWS_DELAY; // (R10)
               else if (stop_exec)
                  state_r <= SWS_STOPPED;
            end
            SWS_STOPPED:
            begin
               if (delay_load)
                  state_r <= SWS_DELAY; // (R19)
            end
            SWS_DELAY:
            begin
               if (delay_done)
               begin
                  state_r <= SWS_RESUME; // (R20)
                  resume_cnt_r <= RESUME_LOAD; // (R08)
               end
            end
            SWS_RESUME:
            begin
               if (resume_cnt_r == CNT_W'(1))
                  state_r <= SWS_RUN;
               resume_cnt_r <= resume_cnt_r - CNT_W'(1);
            end
            SWS_DEBUG:
            begin
               if (debug_release)
                  state_r <= SWS_RUN; // (R16)
            end
            default:
               state_r <= SWS_RUN;
         endcase
      end
   end

   // Wake must stay low across the whole resume window to be serviced
   logic wake_held_r;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         wake_held_r <= 1'b0;
      else if (delay_done)
         wake_held_r <= wake_low_r; // (R02)
      else if (state_r == SWS_RESUME)
         wake_held_r <= wake_held_r && wake_low_r; // (R02)
   end

   logic last_resume;
   sws_exit_t exit_kind;
   assign last_resume = (state_r == SWS_RESUME) && (resume_cnt_r == CNT_W'(1));
   always_comb
   begin
      if (higher_pending)
         exit_kind = SWS_EXIT_HIGHER; // (R03)
      else if (wake_held_r && wake_low_r && wake_level_mode)
         exit_kind = SWS_EXIT_VECTOR; // (R01) (R05)
      else
         exit_kind = SWS_EXIT_NEXT; // (R04)
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         resume_pulse <= 1'b0;
         vector_fetch <= 1'b0;
         higher_grant <= 1'b0;
         fetch_addr <= 16'h0000;
      end
      else
      begin
         resume_pulse <= last_resume;
         vector_fetch <= last_resume && (exit_kind == SWS_EXIT_VECTOR); // (R05)
         higher_grant <= last_resume && (exit_kind == SWS_EXIT_HIGHER); // (R03)
         if (last_resume && exit_kind == SWS_EXIT_VECTOR)
            fetch_addr <= WAKE_VECTOR_ADDR; // (R05)
         else if (vector_fetch)
            fetch_addr <= WAKE_VECTOR_ADDR2; // (R05)
      end
   end

   // Clock gating follows state; oscillator keeps running unless truly stopped
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         core_clk_en <= 1'b1;
         osc_en <= 1'b1;
         stopped <= 1'b0;
         debug_halt <= 1'b0;
      end
      else
      begin
         core_clk_en <= (state_r == SWS_RUN) || (state_r == SWS_RESUME); // (R10)
         osc_en <= (state_r != SWS_STOPPED); // (R10) (R19)
         stopped <= (state_r == SWS_STOPPED) || (state_r == SWS_DELAY);
         debug_halt <= (state_r == SWS_DEBUG); // (R16)
      end
   end

   // Stack error is sticky across stop; set beats acknowledge
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         stack_err_pending <= 1'b0; // (R13)
      else if (stack_err_set)
         stack_err_pending <= 1'b1; // (R06)
      else if (stack_err_ack)
         stack_err_pending <= 1'b0;
   end

   // Edge requests are dropped on stop entry and throughout the delay
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         edge_irq_pending <= 1'b0; // (R13)
      else if (state_r == SWS_DELAY || state_r == SWS_STOPPED || stop_exec)
         edge_irq_pending <= 1'b0; // (R12)
      else if (edge_irq_set)
         edge_irq_pending <= 1'b1;
      else if (resume_pulse)
         edge_irq_pending <= edge_irq_pending;
   end

   // Assertions
   a_edge_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (state_r == SWS_DELAY) |=> !edge_irq_pending) // (R12)
      else $error("edge request held during delay");
   a_stack_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stack_err_pending && !stack_err_ack |=> stack_err_pending) // (R06)
      else $error("stack error lost");
   a_vector_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vector_fetch |-> fetch_addr == WAKE_VECTOR_ADDR ##1 fetch_addr == WAKE_VECTOR_ADDR2) // (R05)
      else $error("wrong vector pair");
   a_edge_no_vec: assert property (@(posedge sys_clk) disable iff (!rst_n)
      last_resume && !wake_level_mode |=> !vector_fetch) // (R01)
      else $error("edge mode serviced");
   a_higher_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      last_resume && higher_pending |=> higher_grant && !vector_fetch) // (R03)
      else $error("higher level lost");
   a_next_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
      last_resume && !wake_low_r && !higher_pending |=> !vector_fetch && resume_pulse) // (R04)
      else $error("no plain resume");
   a_short_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
      delay_load && stop_delay_select |=> ##8 delay_done) // (R17)
      else $error("short delay wrong");
   a_resume_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      delay_done |=> (state_r == SWS_RESUME)[*8] ##1 (state_r == SWS_RESUME)[*8]
      ##1 resume_pulse) // (R08)
      else $error("resume length wrong");
   a_nop_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_r == SWS_RUN && stop_exec && wake_low_r && !debug_req |=> ##1 osc_en) // (R10)
      else $error("oscillator stopped on nop");
   a_debug_halt: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_r == SWS_DEBUG |=> debug_halt && !core_clk_en) // (R16)
      else $error("debug not halted");
   c_vector: cover property (@(posedge sys_clk) disable iff (!rst_n) vector_fetch);
   c_plain: cover property (@(posedge sys_clk) disable iff (!rst_n)
      resume_pulse && !vector_fetch);
   c_nop: cover property (@(posedge sys_clk) disable iff (!rst_n)
      state_r == SWS_RUN && stop_exec && wake_low_r);
   c_debug: cover property (@(posedge sys_clk) disable iff (!rst_n) debug_halt);
endmodule : sws_sequencer

// >>> verification/sws_wake_src.sv
// Purpose: Model of the outside party driving the active-low wake line
// Assumes: The line has a pull-up, so a released line reads high
// Notes: Holds the line until feedback unless a brief pulse is asked for
`timescale 1ns/10ps
module sws_wake_src
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control from bench
   input wire logic go,
   input wire logic brief,
   input wire logic feedback,
   // Wake line
   output logic ext_wake_int_a_n
);
   logic hold_r;
   logic [1:0] left_r;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         hold_r <= 1'b0;
         left_r <= 2'h0;
      end
      else if (go)
      begin
         hold_r <= !brief;
         left_r <= brief ? 2'h2 : 2'h0;
      end
      else
      begin
         // Recovery time is unknown, so only feedback may end the hold
         if (feedback)
            hold_r <= 1'b0;
         if (left_r != 2'h0)
            left_r <= left_r - 2'h1;
      end
   end
   assign ext_wake_int_a_n = !(hold_r || left_r != 2'h0);
endmodule : sws_wake_src

// >>> verification/tb.sv
// Purpose: Self-checking bench for the stop-state wakeup sequencer
// Assumes: Long delay shortened to 64 T; exit time window allows pipeline slack
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module tb;
   import sws_pkg::*;
   localparam int LONG_T = 64;
   localparam int SHORT_T = 16;
   localparam int SLACK = 6;
   // Resume covers the eight stop cycles after the delay, in clocks
   localparam int RES = int'(STOP_INSTR_T / T_PER_CLK);
   logic sys_clk, rst_n, stop_exec, debug_req, debug_release, stop_delay_select;
   logic wake_level_mode, timer_zero, higher_pending, stack_err_set, stack_err_ack;
   logic edge_irq_set, ext_wake_int_a_n, core_clk_en, osc_en, stopped, debug_halt;
   logic resume_pulse, vector_fetch, higher_grant, stack_err_pending, edge_irq_pending;
   logic go, brief, vf, gr, osc_lo;
   logic [15:0] fetch_addr, fa, fa2;
   int errors, n_tests, n, d;
   sws_sequencer #(.LONG_DELAY(LONG_T), .SHORT_DELAY(SHORT_T)) i_dut (.sys_clk, .rst_n,
      .stop_exec, .debug_req, .debug_release, .stop_delay_select, .wake_level_mode,
      .timer_zero, .higher_pending, .stack_err_set, .stack_err_ack, .edge_irq_set,
      .ext_wake_int_a_n, .core_clk_en, .osc_en, .stopped, .debug_halt, .resume_pulse,
      .vector_fetch, .fetch_addr, .higher_grant, .stack_err_pending, .edge_irq_pending);
   sws_wake_src i_src (.sys_clk, .rst_n, .go, .brief, .feedback(resume_pulse),
      .ext_wake_int_a_n);
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = !sys_clk;
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (!ok)
      begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask : pulse
   task automatic enter_stop();
      pulse(stop_exec);
      tick(1);
      chk(stopped === 1'b1 && osc_en === 1'b0 && core_clk_en === 1'b0, "stop entry");
   endtask : enter_stop
   // Source 0 holds the line, 1 pulses it briefly, 2 fires the timer, 3 none
   task automatic run_exit(input int src);
      n = 0;
      osc_lo = 1'b0;
      brief = (src == 1);
      if (src < 2)
         pulse(go);
      if (src == 2)
         pulse(timer_zero);
      while (resume_pulse !== 1'b1 && n < 2000)
      begin
         if (osc_en !== 1'b1)
            osc_lo = 1'b1;
         tick(1);
         n++;
      end
      if (n >= 2000)
      begin
         errors++;
         $display("mismatch at %0t: no resume", $time);
         give_verdict();
      end
      else
      begin
         vf = vector_fetch;
         gr = higher_grant;
         fa = fetch_addr;
         tick(1);
         fa2 = fetch_addr;
         tick(3);
      end
   endtask : run_exit
   initial
   begin
      {rst_n, stop_exec, debug_req, debug_release, timer_zero, go, brief} = '0;
      {higher_pending, stack_err_set, stack_err_ack, edge_irq_set} = '0;
      stop_delay_select = 1'b1;
      wake_level_mode = 1'b1;
      errors = 0;
      n_tests = 0;
      tick(16);
      rst_n = 1'b1;
      tick(1);
      chk(core_clk_en === 1'b1 && osc_en === 1'b1 && stopped === 1'b0, "reset out");
      for (int s = 0; s < 2; s++)
      begin
         stop_delay_select = (s == 0);
         d = (s == 0) ? SHORT_T / 2 : LONG_T / 2;
         enter_stop();
         run_exit(0);
         chk(n >= d + RES && n <= d + RES + SLACK, "exit time");
         chk(vf === 1'b1 && fa === 16'h0010 && fa2 === 16'h0011, "vector pair");
      end
      $display("test wake exits ended");
      wake_level_mode = 1'b0;
      enter_stop();
      run_exit(0);
      chk(vf === 1'b0, "edge mode vector");
      wake_level_mode = 1'b1;
      higher_pending = 1'b1;
      enter_stop();
      run_exit(0);
      chk(gr === 1'b1 && vf === 1'b0, "higher level");
      higher_pending = 1'b0;
      enter_stop();
      run_exit(1);
      chk(vf === 1'b0 && n >= d + RES && n <= d + RES + SLACK, "brief pulse");
      enter_stop();
      run_exit(2);
      chk(vf === 1'b0, "timer wake");
      $display("test exit sources ended");
      pulse(stack_err_set);
      pulse(edge_irq_set);
      tick(1);
      chk(stack_err_pending === 1'b1 && edge_irq_pending === 1'b1, "pending set");
      enter_stop();
      chk(edge_irq_pending === 1'b0, "edge cleared");
      pulse(edge_irq_set);
      tick(1);
      chk(edge_irq_pending === 1'b0, "edge ignored");
      run_exit(0);
      chk(stack_err_pending === 1'b1, "stack kept");
      pulse(go);
      tick(2);
      pulse(stop_exec);
      run_exit(3);
      chk(osc_lo === 1'b0 && n >= d + RES && n <= d + RES + SLACK, "stop as nop");
      enter_stop();
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(1);
      chk(stopped === 1'b0 && core_clk_en === 1'b1 && stack_err_pending === 1'b0, "rst");
      $display("test pending and reset ended");
      pulse(debug_req);
      tick(1);
      chk(debug_halt === 1'b1, "debug halt");
      pulse(debug_release);
      tick(1);
      chk(debug_halt === 1'b0, "debug leave");
      $display("test debug ended");
      give_verdict();
   end
endmodule : tb
